/* File: rtl/adcc_pkg.sv */
// constants and carriers shared by the converter control block
`default_nettype none
package adcc_pkg;
   // ------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL_A = 8'h0e;
   localparam logic [7:0] ADDR_CTRL_B = 8'h0f;
   localparam logic [7:0] ADDR_RES_HI = 8'h20;
   localparam logic [7:0] ADDR_RES_LO = 8'h21;
   // ------------------------------------------------------------
   // reset values and codes
   // ------------------------------------------------------------
   localparam logic [7:0] CTRL_A_RESET = 8'h10;
   localparam logic [5:0] CTRL_B_RESET = 6'h10;
   localparam logic [9:0] RESULT_RESET = 10'h000;
   localparam logic [1:0] MODE_OFF = 2'h0;
   localparam logic [1:0] MODE_SINGLE = 2'h1;
   localparam logic [1:0] MODE_RSVD = 2'h2;
   localparam logic [1:0] MODE_REPEAT = 2'h3;
   localparam logic [3:0] CHAN_LAST = 4'h5;
   localparam int NUM_CHAN = 6;
   // ------------------------------------------------------------
   // conversion time codes and lengths in fc cycles
   // ------------------------------------------------------------
   localparam logic [2:0] ACK_78 = 3'h2;
   localparam logic [2:0] ACK_156 = 3'h3;
   localparam logic [2:0] ACK_312 = 3'h4;
   localparam logic [2:0] ACK_624 = 3'h5;
   localparam logic [2:0] ACK_1248 = 3'h6;
   localparam logic [10:0] CYC_78 = 11'h04e;
   localparam logic [10:0] CYC_156 = 11'h09c;
   localparam logic [10:0] CYC_312 = 11'h138;
   localparam logic [10:0] CYC_624 = 11'h270;
   localparam logic [10:0] CYC_1248 = 11'h4e0;
   // ------------------------------------------------------------
   // register carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic start;
      logic [1:0] mode;
      logic gate;
      logic [3:0] chan;
   } adcc_ctrl_a_s;
   typedef struct packed {
      logic ladder;
      logic fixed_one;
      logic [2:0] ack;
      logic fixed_zero;
   } adcc_ctrl_b_s;
   typedef struct packed {
      logic [1:0] res_lo;
      logic eoc;
      logic busy;
      logic [3:0] unused;
   } adcc_stat_s;
   function automatic logic [10:0] adcc_conv_len(input logic [2:0] ack);
      logic [10:0] len;
      len = CYC_78;
      unique case (ack)
         ACK_156: len = CYC_156;
         ACK_312: len = CYC_312;
         ACK_624: len = CYC_624;
         ACK_1248: len = CYC_1248;
         default: len = CYC_78;
      endcase
      return len;
   endfunction
endpackage
`default_nettype wire

/* File: rtl/adcc_ctrl.sv */
// control and register logic of the 10-bit successive approximation converter
`default_nettype none
module adcc_ctrl
   import adcc_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic stop_mode,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   input wire logic [9:0] conv_result,
   output logic [NUM_CHAN-1:0] ain_sel,
   output logic ladder_on,
   output logic conv_busy_flag,
   output logic conv_end_flag,
   output logic conv_done_irq
);
   // ------------------------------------------------------------
   // registers and decode
   // ------------------------------------------------------------
   adcc_ctrl_a_s adc_control_a;
   adcc_ctrl_b_s adc_control_b;
   logic [9:0] result;
   logic [10:0] cnt;
   logic mode_run;
   logic start_go;
   logic done;
   logic wr_a;
   logic wr_b;
   logic rd_hi;

   assign wr_a = wr && (addr == ADDR_CTRL_A) && !stop_mode;
   assign wr_b = wr && (addr == ADDR_CTRL_B) && !stop_mode;
   assign rd_hi = rd && (addr == ADDR_RES_HI);
   assign mode_run = (adc_control_a.mode == MODE_SINGLE) ||
                     (adc_control_a.mode == MODE_REPEAT);
   assign start_go = adc_control_a.start && mode_run && !conv_busy_flag
                     && !stop_mode;
   assign done = conv_busy_flag && mode_run && !stop_mode &&
                 (cnt == 11'(adcc_conv_len(adc_control_b.ack) - 11'h001));

   // ------------------------------------------------------------
   // control register a
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         adc_control_a <= CTRL_A_RESET;
      end else if (stop_mode) begin
         adc_control_a <= CTRL_A_RESET;
      end else if (wr_a) begin
         adc_control_a <= wdata;
      end else if (adc_control_a.start) begin
         adc_control_a.start <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // control register b
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         adc_control_b <= CTRL_B_RESET;
      end else if (stop_mode) begin
         adc_control_b <= CTRL_B_RESET;
      end else if (wr_b) begin
         adc_control_b <= wdata[5:0];
      end
   end

   // ------------------------------------------------------------
   // conversion sequencer
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         conv_busy_flag <= 1'b0;
         cnt <= 11'h000;
      end else if (stop_mode) begin
         conv_busy_flag <= 1'b0;
         cnt <= 11'h000;
      end else if (conv_busy_flag && !mode_run) begin
         conv_busy_flag <= 1'b0;
         cnt <= 11'h000;
      end else if (start_go) begin
         conv_busy_flag <= 1'b1;
         cnt <= 11'h000;
      end else if (done) begin
         conv_busy_flag <= (adc_control_a.mode == MODE_REPEAT);
         cnt <= 11'h000;
      end else if (conv_busy_flag) begin
         cnt <= cnt + 11'h001;
      end
   end

   // ------------------------------------------------------------
   // result, end flag and completion pulse
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         result <= RESULT_RESET;
      end else if (stop_mode) begin
         result <= RESULT_RESET;
      end else if (done) begin
         result <= conv_result;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         conv_end_flag <= 1'b0;
      end else if (stop_mode) begin
         conv_end_flag <= 1'b0;
      end else if (done) begin
         conv_end_flag <= 1'b1;
      end else if (start_go || rd_hi) begin
         conv_end_flag <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         conv_done_irq <= 1'b0;
      end else begin
         conv_done_irq <= done;
      end
   end

   // ------------------------------------------------------------
   // analog side controls
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ladder_on <= 1'b0;
      end else begin
         ladder_on <= !stop_mode &&
                      (adc_control_b.ladder || conv_busy_flag || start_go);
      end
   end

   for (genvar i = 0; i < NUM_CHAN; i++) begin : g_sel
      always_ff @(posedge clk or negedge arst_n) begin
         if (!arst_n) begin
            ain_sel[i] <= 1'b0;
         end else begin
            ain_sel[i] <= !stop_mode && !adc_control_a.gate &&
                          (adc_control_a.chan == 4'(i));
         end
      end
   end

   // ------------------------------------------------------------
   // read port
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata <= 8'h00;
      end else if (rd) begin
         unique case (addr)
            ADDR_CTRL_A: rdata <= adc_control_a;
            ADDR_CTRL_B: rdata <= {2'b00, adc_control_b};
            ADDR_RES_HI: rdata <= result[9:2];
            ADDR_RES_LO: rdata <= adcc_stat_s'({result[1:0], conv_end_flag,
                                                conv_busy_flag, 4'h0});
            default: rdata <= 8'h00;
         endcase
      end else begin
         rdata <= 8'h00;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   logic [10:0] span;
   logic repeat_seen;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         span <= 11'h000;
      end else if (start_go || done) begin
         span <= 11'h000;
      end else if (conv_busy_flag) begin
         span <= span + 11'h001;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         repeat_seen <= 1'b0;
      end else if (!conv_busy_flag) begin
         repeat_seen <= 1'b0;
      end else if (done && adc_control_a.mode == MODE_REPEAT) begin
         repeat_seen <= 1'b1;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   a_start_self_clear: assert property (
      start_go |=> conv_busy_flag && !adc_control_a.start)
      else $error("start bit did not launch and clear");

   a_start_refused: assert property (
      adc_control_a.start && !mode_run && !conv_busy_flag |=> !conv_busy_flag)
      else $error("start launched in off or reserved mode");

   a_mode_abort: assert property (
      conv_busy_flag && adc_control_a.mode == MODE_OFF && !stop_mode
      |=> !conv_busy_flag && !conv_done_irq ##1 !conv_done_irq)
      else $error("off mode did not abort conversion");

   a_repeat_restart: assert property (
      done && adc_control_a.mode == MODE_REPEAT |=> conv_busy_flag && cnt == 11'h000)
      else $error("repeat mode did not restart");

   a_conv_span: assert property (
      done |-> span == 11'(adcc_conv_len(adc_control_b.ack) - 11'h001))
      else $error("conversion length wrong");

   a_conv_78: assert property (
      conv_done_irq && $past(adc_control_b.ack) == ACK_78 |-> $past(span) == 11'h04d)
      else $error("78 cycle conversion not 78 cycles");

   a_done_store: assert property (
      done |=> conv_end_flag && conv_done_irq && rdata == 8'h00 ||
               conv_end_flag && conv_done_irq && $past(rd))
      else $error("completion did not set flag and pulse");

   a_result_kept: assert property (
      done |=> result == $past(conv_result))
      else $error("result not stored at completion");

   a_read_clear: assert property (
      rd_hi && !done && !stop_mode |=> !conv_end_flag)
      else $error("result read did not clear end flag");

   a_stop_init: assert property (
      stop_mode |=> adc_control_a == CTRL_A_RESET && adc_control_b == CTRL_B_RESET
                    && !conv_busy_flag)
      else $error("stop mode did not initialise");

   a_ctrlb_upper: assert property (
      rd && addr == ADDR_CTRL_B |=> rdata[7:6] == 2'b00)
      else $error("control b upper bits not zero");

   a_ladder_cause: assert property (
      ladder_on |-> $past(adc_control_b.ladder || conv_busy_flag || start_go))
      else $error("ladder connected without cause");

   a_input_gate: assert property (
      |ain_sel |-> $past(!adc_control_a.gate && adc_control_a.chan <= CHAN_LAST))
      else $error("input selected while gated or reserved");

   a_irq_pulse: assert property (
      conv_done_irq |=> !conv_done_irq)
      else $error("completion pulse longer than one cycle");

   a_input_onehot: assert property (
      $onehot0(ain_sel))
      else $error("more than one analog input selected");

   a_single_idle: assert property (
      done && adc_control_a.mode == MODE_SINGLE |=> !conv_busy_flag)
      else $error("busy still set after single conversion");

   c_single_done: cover property (
      conv_done_irq && adc_control_a.mode == MODE_SINGLE && !conv_busy_flag);
   c_repeat_again: cover property (done && repeat_seen);
   c_abort: cover property (
      conv_busy_flag && adc_control_a.mode == MODE_OFF);
   c_read_clear: cover property (conv_end_flag && rd_hi);
   c_stop_abort: cover property (conv_busy_flag && stop_mode);
endmodule
`default_nettype wire

/* File: bench/adcc_ctrl_test.sv */
// self-checking bench for the converter control block
`default_nettype none
module adcc_ctrl_test
   import adcc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------
   // signals and design instance
   // ------------------------------------------------------------
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic stop_mode = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] rdata;
   logic [9:0] conv_result = 10'h000;
   logic [NUM_CHAN-1:0] ain_sel;
   logic ladder_on;
   logic conv_busy_flag;
   logic conv_end_flag;
   logic conv_done_irq;
   int n_errors = 0;
   int samples_checked = 0;
   logic [31:0] seed = 32'hee8d;
   logic [9:0] res;
   int cyc;
   int hits;
   adcc_ctrl adcc_ctrl_inst (.clk(clk), .arst_n(arst_n), .stop_mode(stop_mode), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .conv_result(conv_result),
      .ain_sel(ain_sel), .ladder_on(ladder_on), .conv_busy_flag(conv_busy_flag),
      .conv_end_flag(conv_end_flag), .conv_done_irq(conv_done_irq));
   always #10 clk = ~clk;
   // ------------------------------------------------------------
   // model, bus tasks and compare
   // ------------------------------------------------------------
   function automatic int model_len(input int k);
      return (k >= 2 && k <= 6) ? (78 << (k - 2)) : 78;
   endfunction
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      x = x ^ (x << 5);
      return x;
   endfunction
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(what, exp, rdata);
   endtask
   task automatic wait_irq(input int c0, output int c);
      c = c0;
      while (conv_done_irq !== 1'b1 && c < 1400) begin
         @(posedge clk);
         #1;
         c++;
      end
   endtask
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      #200000;
      n_errors++;
      summarize();
   end
   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      rd_chk("ctrl_a reset", ADDR_CTRL_A, 8'h10);
      rd_chk("ctrl_b reset", ADDR_CTRL_B, 8'h10);
      rd_chk("res_hi reset", ADDR_RES_HI, 8'h00);
      rd_chk("unmapped", 8'h33, 8'h00);
      $display("test reset done");
      for (int k = 2; k <= 6; k++) begin
         seed = xs(seed);
         res = seed[9:0];
         @(posedge clk);
         conv_result <= res;
         wr_reg(ADDR_CTRL_B, {2'h0, 1'b0, 1'b1, k[2:0], 1'b0});
         wr_reg(ADDR_CTRL_A, {1'b1, MODE_SINGLE, 1'b0, k[3:0] - 4'h2});
         #1;
         @(posedge clk);
         #1;
         chk("busy", 8'h01, {7'h0, conv_busy_flag});
         chk("ladder", 8'h01, {7'h0, ladder_on});
         chk("ain_sel", 8'h01 << (k - 2), {2'h0, ain_sel});
         wait_irq(2, cyc);
         chk("conv len", model_len(k) + 2, cyc[7:0]);
         rd_chk("res_lo", ADDR_RES_LO, {res[1:0], 1'b1, 1'b0, 4'h0});
         rd_chk("res_hi", ADDR_RES_HI, res[9:2]);
         chk("end flag", 8'h00, {7'h0, conv_end_flag});
         chk("ladder idle", 8'h00, {7'h0, ladder_on});
         rd_chk("start clear", ADDR_CTRL_A, {1'b0, MODE_SINGLE, 1'b0, k[3:0] - 4'h2});
      end
      $display("test single done");
      for (int g = 0; g < 2; g++) begin
         for (int c = 0; c < 16; c++) begin
            wr_reg(ADDR_CTRL_A, {1'b0, MODE_OFF, g[0], c[3:0]});
            repeat (2) @(posedge clk);
            #1;
            chk("ain_sel", (g == 0 && c < 6) ? (8'h01 << c) : 8'h00, {2'h0, ain_sel});
         end
      end
      $display("test channel done");
      for (int m = 0; m < 3; m += 2) begin
         wr_reg(ADDR_CTRL_A, {1'b1, m[1:0], 1'b0, 4'h1});
         repeat (3) @(posedge clk);
         #1;
         chk("no start", 8'h00, {7'h0, conv_busy_flag});
         rd_chk("start clear", ADDR_CTRL_A, {1'b0, m[1:0], 1'b0, 4'h1});
      end
      $display("test refused start done");
      wr_reg(ADDR_CTRL_B, 8'h34);
      wr_reg(ADDR_CTRL_A, {1'b1, MODE_REPEAT, 1'b0, 4'h5});
      #1;
      wait_irq(1, cyc);
      chk("first len", 8'd80, cyc[7:0]);
      @(posedge clk);
      #1;
      chk("repeat busy", 8'h01, {7'h0, conv_busy_flag});
      wait_irq(1, cyc);
      chk("repeat len", 8'd78, cyc[7:0]);
      wr_reg(ADDR_CTRL_A, {1'b0, MODE_OFF, 1'b0, 4'h5});
      @(posedge clk);
      #1;
      chk("abort busy", 8'h00, {7'h0, conv_busy_flag});
      hits = 0;
      repeat (100) begin
         @(posedge clk);
         #1;
         if (conv_done_irq !== 1'b0) hits++;
      end
      chk("abort irq", 8'h00, hits[7:0]);
      chk("ladder always", 8'h01, {7'h0, ladder_on});
      $display("test repeat done");
      wr_reg(ADDR_CTRL_A, {1'b1, MODE_SINGLE, 1'b0, 4'h3});
      repeat (5) @(posedge clk);
      stop_mode <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk("stop busy", 8'h00, {7'h0, conv_busy_flag});
      wr_reg(ADDR_CTRL_A, 8'h45);
      wr_reg(ADDR_CTRL_B, 8'h3c);
      rd_chk("stop ctrl_a", ADDR_CTRL_A, 8'h10);
      rd_chk("stop ctrl_b", ADDR_CTRL_B, 8'h10);
      @(posedge clk);
      stop_mode <= 1'b0;
      wr_reg(ADDR_CTRL_A, 8'h03);
      rd_chk("run ctrl_a", ADDR_CTRL_A, 8'h03);
      $display("test stop done");
      summarize();
   end
endmodule
`default_nettype wire
